// ### core/conv_cfg_pkg.sv
// constants, codes and carrier types of the output interface and power-down registers
// ----------------------------------------------------------------
// Contract
// R1: mapper field picks the output bit mapping
// R2: written mapper acts only after fuse load
// R3: fuse load clears other serial writes
// R4: fuse defaults load after reset automatically
// R5: unwritten mapper and mode read back zero
// R6: mode select needs change enable set
// R7: mode field picks the output interface
// R8: bit 5 sleeps the clock buffer
// R9: bit 4 sleeps the reference amplifier
// R10: bit 2 sleeps channel A
// R11: bit 0 global sleep, mask exempts blocks
// R12: mask bit 3 keeps clock buffer awake
// R13: disable bits sleep each output buffer
// R14: serial modes need buffer bit 3 disabled; the bank does not force it, the controller must write it
// R15: controller writes documented reserved values
// ----------------------------------------------------------------
package conv_cfg_pkg;
  // register offsets
  localparam logic [11:0] OFF_SOFT_RESET = 12'h000;
  localparam logic [11:0] OFF_IF_SELECT = 12'h007;
  localparam logic [11:0] OFF_POWER_DOWN = 12'h008;
  localparam logic [11:0] OFF_OBD_LOW = 12'h00a;
  localparam logic [11:0] OFF_OBD_MID = 12'h00b;
  localparam logic [11:0] OFF_OBD_HIGH = 12'h00c;
  localparam logic [11:0] OFF_SLEEP_MASK = 12'h00d;
  localparam logic [11:0] OFF_FUSE_LOAD = 12'h013;
  // field positions
  localparam int MAP_HI = 7;
  localparam int MAP_LO = 5;
  localparam int IF_EN_BIT = 3;
  localparam int MODE_HI = 2;
  localparam int MODE_LO = 0;
  localparam int PD_CLKBUF_BIT = 5;
  localparam int PD_REFAMP_BIT = 4;
  localparam int PD_CHAN_A_BIT = 2;
  localparam int PD_GLOBAL_BIT = 0;
  localparam int KEEP_CLK_BUF_BIT = 3;
  localparam int KEEP_REF_AMP_BIT = 2;
  localparam int CMD_BIT = 0;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_POWER_DOWN = 8'h02;
  // bit mapping codes
  localparam logic [2:0] MAP_TWO_WIRE_18 = 3'h1;
  localparam logic [2:0] MAP_TWO_WIRE_16 = 3'h2;
  localparam logic [2:0] MAP_ONE_WIRE = 3'h3;
  localparam logic [2:0] MAP_HALF_WIRE = 3'h4;
  localparam logic [2:0] MAP_DOUBLE_RATE = 3'h5;
  localparam logic [2:0] MAP_SINGLE_RATE = 3'h6;
  // interface mode codes
  localparam logic [2:0] MODE_SINGLE_RATE = 3'h0;
  localparam logic [2:0] MODE_DOUBLE_RATE = 3'h1;
  localparam logic [2:0] MODE_TWO_WIRE = 3'h3;
  localparam logic [2:0] MODE_ONE_WIRE = 3'h4;
  localparam logic [2:0] MODE_HALF_WIRE = 3'h5;
  // serial frame layout: 16 header bits then 8 data bits
  localparam logic [4:0] HEAD_LAST = 5'h0f;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] FRAME_DONE = 5'h18;
  localparam int RW_BIT = 15;
  // serial port states
  typedef enum logic [2:0] {
    SIO_IDLE = 3'b001,
    SIO_HEAD = 3'b010,
    SIO_BODY = 3'b100
  } sio_state_t;
  // one register write taken from the serial port
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
  } wr_frame_t;
  // sleep controls of the analog blocks
  typedef struct packed {
    logic clk_buf;
    logic ref_amp;
    logic chan_a;
  } sleep_t;
endpackage : conv_cfg_pkg

// ### core/serial_frame_port.sv
// serial register port: frame shifter, read launch and write strobe
`timescale 1ns/100ps
`default_nettype none
module serial_frame_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // synchronised pin levels
  input wire logic sen_n_i,
  input wire logic sclk_i,
  input wire logic sdio_i,
  // register file side
  input wire logic [7:0] rd_data_i,
  output logic [11:0] rd_addr_o,
  output logic wr_stb_o,
  output conv_cfg_pkg::wr_frame_t wr_frame_o,
  // data pin drive
  output logic sdio_o,
  output logic sdio_oe_o
);
  conv_cfg_pkg::sio_state_t state_q, state_d; // frame phase
  logic sclk_d_q; // previous clock level, for edges
  logic [4:0] cnt_q; // clock rises seen in frame
  logic [15:0] head_q; // header shifter
  logic rw_q; // frame is a read
  logic load_q; // fetch read data next cycle
  logic [7:0] out_q; // read data shifter
  logic [11:0] addr_q; // captured register address
  logic stb_q; // write strobe
  logic [7:0] wdata_q; // captured write data
  logic sdo_q; // launched bit
  logic oe_q; // pin drive enable
  wire rise = sclk_i & ~sclk_d_q;
  wire fall = ~sclk_i & sclk_d_q;
  wire head_end = rise && (state_q == conv_cfg_pkg::SIO_HEAD) && (cnt_q == conv_cfg_pkg::HEAD_LAST);
  wire in_body = (state_q == conv_cfg_pkg::SIO_BODY);
  wire launch = fall && in_body && rw_q;
  // ----------------------------------------------------------------
  // frame phase
  // ----------------------------------------------------------------
  // select high always abandons the frame, so a cut frame never writes
  always_comb begin
    state_d = state_q;
    case (state_q)
      conv_cfg_pkg::SIO_IDLE: begin
        if (!sen_n_i) state_d = conv_cfg_pkg::SIO_HEAD;
      end
      conv_cfg_pkg::SIO_HEAD: begin
        if (sen_n_i) state_d = conv_cfg_pkg::SIO_IDLE;
        else if (head_end) state_d = conv_cfg_pkg::SIO_BODY;
      end
      conv_cfg_pkg::SIO_BODY: begin
        if (sen_n_i) state_d = conv_cfg_pkg::SIO_IDLE;
      end
      default: state_d = conv_cfg_pkg::SIO_IDLE;
    endcase
  end
  // ----------------------------------------------------------------
  // shifters and strobes
  // ----------------------------------------------------------------
  // counter saturates so long frames cannot wrap into a second write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= conv_cfg_pkg::SIO_IDLE;
      sclk_d_q <= 1'b0;
      cnt_q <= 5'h00;
      head_q <= 16'h0000;
      rw_q <= 1'b0;
      addr_q <= 12'h000;
      load_q <= 1'b0;
      out_q <= 8'h00;
      stb_q <= 1'b0;
      wdata_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sclk_d_q <= sclk_i;
      if (sen_n_i) cnt_q <= 5'h00;
      else if (rise && cnt_q != conv_cfg_pkg::FRAME_DONE) cnt_q <= cnt_q + 5'h01;
      if (rise) head_q <= {head_q[14:0], sdio_i};
      if (head_end) begin
        addr_q <= {head_q[10:0], sdio_i};
        rw_q <= head_q[conv_cfg_pkg::RW_BIT - 1];
      end
      load_q <= head_end && head_q[conv_cfg_pkg::RW_BIT - 1];
      // read data leaves on falling edges, msb first
      if (load_q) out_q <= rd_data_i;
      else if (launch) out_q <= {out_q[6:0], 1'b0};
      if (launch) sdo_q <= out_q[7];
      if (sen_n_i || !in_body) oe_q <= 1'b0;
      else if (launch) oe_q <= 1'b1;
      stb_q <= rise && in_body && !rw_q && (cnt_q == conv_cfg_pkg::FRAME_LAST);
      if (rise && in_body && (cnt_q == conv_cfg_pkg::FRAME_LAST)) wdata_q <= {head_q[6:0], sdio_i};
    end
  end
  assign rd_addr_o = addr_q;
  assign wr_stb_o = stb_q;
  assign wr_frame_o = '{addr: addr_q, data: wdata_q};
  assign sdio_o = sdo_q;
  assign sdio_oe_o = oe_q;
endmodule : serial_frame_port
`default_nettype wire

// ### core/conv_cfg_regs.sv
// output interface selection and power-down register bank of the converter
`timescale 1ns/100ps
`default_nettype none
module conv_cfg_regs #(
  parameter logic [2:0] FUSE_MAPPER = 3'h6, // fuse image of the bit mapping
  parameter logic [2:0] FUSE_MODE = 3'h0, // fuse image of the interface mode
  parameter int OBD_W = 24 // output buffer disable width
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // serial register pins
  input wire logic SEN_N_I,
  input wire logic SCLK_I,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE_O,
  // active output interface
  output logic [2:0] ACTIVE_MAPPING_O,
  output logic [2:0] ACTIVE_MODE_O,
  // analog sleep controls
  output logic CLOCK_BUFFER_SLEEP_O,
  output logic REFERENCE_AMP_SLEEP_O,
  output logic CHANNEL_A_SLEEP_O,
  // parallel output buffer disables
  output logic [OBD_W-1:0] OUTPUT_BUFFER_DISABLE_O
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_q; // first stage, read only by second
  logic [2:0] sync2_q; // safe levels: select, clock, data
  wire [2:0] pins_raw = {SEN_N_I, SCLK_I, SDIO_I};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      // select resets high so no frame is seen during reset
      always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
          sync1_q[gi] <= (gi == 2);
          sync2_q[gi] <= (gi == 2);
        end else begin
          sync1_q[gi] <= pins_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  logic [11:0] rd_addr; // address of the current read
  logic [7:0] rd_data; // register read back
  logic wr_stb; // one-cycle write pulse
  conv_cfg_pkg::wr_frame_t wr_frame; // write address and data
  serial_frame_port u_port (
    .clk_i(MCLK_I),
    .rst_i(SRST_I),
    .sen_n_i(sync2_q[2]),
    .sclk_i(sync2_q[1]),
    .sdio_i(sync2_q[0]),
    .rd_data_i(rd_data),
    .rd_addr_o(rd_addr),
    .wr_stb_o(wr_stb),
    .wr_frame_o(wr_frame),
    .sdio_o(SDIO_O),
    .sdio_oe_o(SDIO_OE_O)
  );
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // true when a write strobe targets the given offset
  function automatic logic wr_hit(input logic stb, input logic [11:0] a, input logic [11:0] off);
    wr_hit = stb && (a == off);
  endfunction : wr_hit
  // mapper codes that name a real mapping
  function automatic logic map_ok(input logic [2:0] c);
    map_ok = (c >= conv_cfg_pkg::MAP_TWO_WIRE_18) && (c <= conv_cfg_pkg::MAP_SINGLE_RATE);
  endfunction : map_ok
  // mode codes that name a real interface
  function automatic logic mode_ok(input logic [2:0] c);
    mode_ok = (c == conv_cfg_pkg::MODE_SINGLE_RATE) || (c == conv_cfg_pkg::MODE_DOUBLE_RATE)
      || (c == conv_cfg_pkg::MODE_TWO_WIRE) || (c == conv_cfg_pkg::MODE_ONE_WIRE)
      || (c == conv_cfg_pkg::MODE_HALF_WIRE);
  endfunction : mode_ok
  wire wr_soft = wr_hit(wr_stb, wr_frame.addr, conv_cfg_pkg::OFF_SOFT_RESET)
    && wr_frame.data[conv_cfg_pkg::CMD_BIT];
  wire wr_fuse = wr_hit(wr_stb, wr_frame.addr, conv_cfg_pkg::OFF_FUSE_LOAD)
    && wr_frame.data[conv_cfg_pkg::CMD_BIT];
  wire wr_ifsel = wr_hit(wr_stb, wr_frame.addr, conv_cfg_pkg::OFF_IF_SELECT);
  wire wr_pdn = wr_hit(wr_stb, wr_frame.addr, conv_cfg_pkg::OFF_POWER_DOWN);
  wire wr_mask = wr_hit(wr_stb, wr_frame.addr, conv_cfg_pkg::OFF_SLEEP_MASK);
  wire [2:0] wr_obd = {wr_hit(wr_stb, wr_frame.addr, conv_cfg_pkg::OFF_OBD_HIGH),
    wr_hit(wr_stb, wr_frame.addr, conv_cfg_pkg::OFF_OBD_MID),
    wr_hit(wr_stb, wr_frame.addr, conv_cfg_pkg::OFF_OBD_LOW)};
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] ifsel_q; // interface select, reads as stored
  logic map_written_q; // mapper field written since reset
  logic [7:0] pdn_q; // power-down control
  logic [7:0] mask_q; // global sleep mask
  logic [OBD_W-1:0] obd_q; // output buffer disables
  wire [2:0] map_field = ifsel_q[conv_cfg_pkg::MAP_HI:conv_cfg_pkg::MAP_LO];
  wire [2:0] mode_field = ifsel_q[conv_cfg_pkg::MODE_HI:conv_cfg_pkg::MODE_LO];
  wire if_en = ifsel_q[conv_cfg_pkg::IF_EN_BIT];
  // fields start at zero, so unwritten fields read 000 while fuses rule
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      ifsel_q <= conv_cfg_pkg::RST_ZERO; // R5
      map_written_q <= 1'b0;
    end else if (wr_soft) begin
      ifsel_q <= conv_cfg_pkg::RST_ZERO;
      map_written_q <= 1'b0;
    end else if (wr_ifsel) begin
      ifsel_q <= wr_frame.data;
      map_written_q <= 1'b1;
    end
  end
  // fuse load wipes every other serial write, only the select survives
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || wr_soft || wr_fuse) begin
      pdn_q <= conv_cfg_pkg::RST_POWER_DOWN; // R3
      mask_q <= conv_cfg_pkg::RST_ZERO;
    end else begin
      if (wr_pdn) pdn_q <= wr_frame.data;
      if (wr_mask) mask_q <= wr_frame.data;
    end
  end
  generate
    for (gi = 0; gi < OBD_W / 8; gi++) begin : g_obd
      // one byte lane of the buffer disable field
      always_ff @(posedge MCLK_I) begin
        if (SRST_I || wr_soft || wr_fuse) obd_q[gi*8 +: 8] <= conv_cfg_pkg::RST_ZERO; // R3
        else if (wr_obd[gi]) obd_q[gi*8 +: 8] <= wr_frame.data;
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // active interface
  // ----------------------------------------------------------------
  logic [2:0] map_q; // mapping in force
  logic [2:0] mode_q; // mode in force
  // a written mapping waits for the fuse load; a bad code loads the fuse mapping instead
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || wr_soft) map_q <= FUSE_MAPPER; // R4
    else if (wr_fuse) map_q <= (map_written_q && map_ok(map_field)) ? map_field : FUSE_MAPPER; // R2
  end
  // mode follows the field only while change is enabled
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) mode_q <= FUSE_MODE; // R4
    else mode_q <= (if_en && mode_ok(mode_field)) ? mode_field : FUSE_MODE; // R6 R7
  end
  assign ACTIVE_MAPPING_O = map_q; // R1
  assign ACTIVE_MODE_O = mode_q;
  // ----------------------------------------------------------------
  // sleep controls
  // ----------------------------------------------------------------
  wire glob = pdn_q[conv_cfg_pkg::PD_GLOBAL_BIT];
  conv_cfg_pkg::sleep_t sleep_d, sleep_q; // analog sleep levels
  // one driver for the whole struct, members gathered in one pattern
  assign sleep_d = '{
    clk_buf: pdn_q[conv_cfg_pkg::PD_CLKBUF_BIT]
      || (glob && !mask_q[conv_cfg_pkg::KEEP_CLK_BUF_BIT]), // R8 R12
    ref_amp: pdn_q[conv_cfg_pkg::PD_REFAMP_BIT]
      || (glob && !mask_q[conv_cfg_pkg::KEEP_REF_AMP_BIT]), // R9 R11
    chan_a: pdn_q[conv_cfg_pkg::PD_CHAN_A_BIT] || glob // R10 R11
  };
  logic [OBD_W-1:0] obd_out_q; // registered buffer disables
  // registered so the analog controls never see decode glitches
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      sleep_q <= '0;
      obd_out_q <= '0;
    end else begin
      sleep_q <= sleep_d;
      obd_out_q <= obd_q; // R13
    end
  end
  assign CLOCK_BUFFER_SLEEP_O = sleep_q.clk_buf;
  assign REFERENCE_AMP_SLEEP_O = sleep_q.ref_amp;
  assign CHANNEL_A_SLEEP_O = sleep_q.chan_a;
  // bit 3 of the low byte shares its pin with the data clock input;
  // the controller must disable it in serial modes, nothing forces it here
  assign OUTPUT_BUFFER_DISABLE_O = obd_out_q; // R14
  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  // command registers self-clear and unmapped offsets read zero
  assign rd_data = (rd_addr == conv_cfg_pkg::OFF_IF_SELECT) ? ifsel_q
    : (rd_addr == conv_cfg_pkg::OFF_POWER_DOWN) ? pdn_q
    : (rd_addr == conv_cfg_pkg::OFF_OBD_LOW) ? obd_q[7:0]
    : (rd_addr == conv_cfg_pkg::OFF_OBD_MID) ? obd_q[15:8]
    : (rd_addr == conv_cfg_pkg::OFF_OBD_HIGH) ? obd_q[23:16]
    : (rd_addr == conv_cfg_pkg::OFF_SLEEP_MASK) ? mask_q
    : conv_cfg_pkg::RST_ZERO;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  a_map_waits: assert property (wr_ifsel && !wr_fuse && !wr_soft |=> $stable(map_q)) // R2
    else $error("mapping changed without fuse load");
  a_map_takes: assert property (wr_fuse && !wr_soft && map_written_q && map_ok(map_field) // R2
    |=> map_q == $past(map_field))
    else $error("fuse load did not apply written mapping");
  a_fuse_wipes: assert property (wr_fuse |=> pdn_q == conv_cfg_pkg::RST_POWER_DOWN // R3
    && obd_q == '0 && mask_q == conv_cfg_pkg::RST_ZERO)
    else $error("fuse load left serial writes in place");
  a_boot_fuse: assert property ($fell(SRST_I) |-> map_q == FUSE_MAPPER && mode_q == FUSE_MODE) // R4
    else $error("fuse defaults not loaded after reset");
  a_read_zero: assert property (!map_written_q |-> ifsel_q == conv_cfg_pkg::RST_ZERO) // R5
    else $error("unwritten select reads nonzero");
  a_mode_gate: assert property (!if_en [*2] |-> mode_q == FUSE_MODE) // R6
    else $error("mode changed while change disabled");
  a_mode_select: assert property (if_en && mode_ok(mode_field) ##1 $stable(ifsel_q) // R7
    |-> mode_q == mode_field)
    else $error("enabled mode not applied");
  // expected level rebuilt from the register bits, not from the sleep struct
  a_clk_sleep: assert property (##1 CLOCK_BUFFER_SLEEP_O == // R8 R12
    $past(pdn_q[conv_cfg_pkg::PD_CLKBUF_BIT]
    || (pdn_q[conv_cfg_pkg::PD_GLOBAL_BIT] && !mask_q[conv_cfg_pkg::KEEP_CLK_BUF_BIT])))
    else $error("clock buffer sleep wrong");
  a_ref_sleep: assert property (pdn_q[conv_cfg_pkg::PD_REFAMP_BIT] |=> REFERENCE_AMP_SLEEP_O) // R9
    else $error("reference amp not asleep");
  a_chan_sleep: assert property ($rose(glob) ##1 glob |-> CHANNEL_A_SLEEP_O) // R11
    else $error("channel A awake in global sleep");
  a_obd_follow: assert property (wr_obd[0] ##2 1'b1 |-> OUTPUT_BUFFER_DISABLE_O[7:0] // R13
    == $past(wr_frame.data, 2))
    else $error("buffer disable byte not applied");
  c_fuse_map: cover property (wr_fuse && map_written_q);
  c_global: cover property (glob && mask_q[conv_cfg_pkg::KEEP_CLK_BUF_BIT]);
  c_read: cover property (SDIO_OE_O);
  c_mode: cover property (if_en && mode_q == conv_cfg_pkg::MODE_ONE_WIRE);
endmodule : conv_cfg_regs
`default_nettype wire

// ### testbench/sio_host_model.sv
// behavioural serial register controller that frames reads and writes
`timescale 1ns/100ps
`default_nettype none
module sio_host_model (
  // clock
  input wire logic clk_i,
  // device drive of the data pin
  input wire logic dev_d_i,
  input wire logic dev_oe_i,
  // pins towards the device
  output logic sen_n_o,
  output logic sclk_o,
  output logic sdio_o
);
  logic drv_q; // level this side puts on the pin
  // resolved pin; a released pin shows the inverse of its last level
  assign sdio_o = dev_oe_i ? dev_d_i : drv_q;
  initial begin
    sen_n_o = 1'b1;
    sclk_o = 1'b0;
    drv_q = 1'b0;
  end
  // one whole frame; slow phases since the device oversamples the pins
  task automatic xfer(input logic rd, input logic [11:0] addr,
                      input logic [7:0] wdat, output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {rd, 3'h0, addr, wdat}; // unused address bits zero
    rdat = 8'h00;
    @(posedge clk_i) #1 sen_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // let go of the pin while the device answers a read
      if (rd && i < 8) drv_q = ~drv_q;
      else drv_q = frame[i];
      repeat (6) @(posedge clk_i);
      #1 if (i < 8) rdat[i] = sdio_o;
      sclk_o = 1'b1;
      repeat (5) @(posedge clk_i);
      #1 sclk_o = 1'b0;
    end
    repeat (5) @(posedge clk_i);
    #1 sen_n_o = 1'b1;
    drv_q = ~drv_q;
    repeat (6) @(posedge clk_i);
  endtask : xfer
endmodule : sio_host_model
`default_nettype wire

// ### testbench/conv_cfg_regs_tb_top.sv
// self-checking bench of the output interface and power-down registers
`timescale 1ns/100ps
`default_nettype none
module conv_cfg_regs_tb_top;
  // fuse images chosen apart from zero so unwritten readback shows
  localparam logic [2:0] F_MAP = 3'h5;
  localparam logic [2:0] F_MODE = 3'h4;
  // one table row: write, then expected outputs
  typedef struct packed {
    logic [11:0] a;
    logic [7:0] d;
    logic [2:0] slp;
    logic [23:0] obd;
    logic [2:0] mode;
  } row_t;
  logic mclk, srst, sen_n, sclk, sdio, sdo, sdo_oe;
  logic [2:0] map, mode;
  logic cbs, ras, cas;
  logic [23:0] obd;
  logic [7:0] r;
  int error_cnt = 0;
  int total_checks = 0;
  row_t rows [18] = '{
    '{12'h007, 8'h21, 3'h0, 24'h0, 3'h4},
    '{12'h007, 8'h2b, 3'h0, 24'h0, 3'h3},
    '{12'h007, 8'h0c, 3'h0, 24'h0, 3'h4},
    '{12'h007, 8'h0d, 3'h0, 24'h0, 3'h5},
    '{12'h007, 8'h08, 3'h0, 24'h0, 3'h0},
    '{12'h007, 8'h09, 3'h0, 24'h0, 3'h1},
    '{12'h007, 8'h0a, 3'h0, 24'h0, 3'h4},
    '{12'h007, 8'h03, 3'h0, 24'h0, 3'h4},
    '{12'h00a, 8'hff, 3'h0, 24'h0000ff, 3'h4},
    '{12'h00b, 8'h5a, 3'h0, 24'h005aff, 3'h4},
    '{12'h00c, 8'ha5, 3'h0, 24'ha55aff, 3'h4},
    '{12'h008, 8'h22, 3'h4, 24'ha55aff, 3'h4},
    '{12'h008, 8'h12, 3'h2, 24'ha55aff, 3'h4},
    '{12'h008, 8'h06, 3'h1, 24'ha55aff, 3'h4},
    '{12'h008, 8'h03, 3'h7, 24'ha55aff, 3'h4},
    '{12'h00d, 8'h08, 3'h3, 24'ha55aff, 3'h4},
    '{12'h00d, 8'h04, 3'h5, 24'ha55aff, 3'h4},
    '{12'h008, 8'h02, 3'h0, 24'ha55aff, 3'h4}
  };
  // -----------------------------------------
  // design, controller model and clock
  // -----------------------------------------
  conv_cfg_regs #(.FUSE_MAPPER(F_MAP), .FUSE_MODE(F_MODE), .OBD_W(24)) u_dut (
    .MCLK_I(mclk), .SRST_I(srst), .SEN_N_I(sen_n), .SCLK_I(sclk),
    .SDIO_I(sdio), .SDIO_O(sdo), .SDIO_OE_O(sdo_oe),
    .ACTIVE_MAPPING_O(map), .ACTIVE_MODE_O(mode),
    .CLOCK_BUFFER_SLEEP_O(cbs), .REFERENCE_AMP_SLEEP_O(ras),
    .CHANNEL_A_SLEEP_O(cas), .OUTPUT_BUFFER_DISABLE_O(obd)
  );
  sio_host_model u_host (
    .clk_i(mclk), .dev_d_i(sdo), .dev_oe_i(sdo_oe),
    .sen_n_o(sen_n), .sclk_o(sclk), .sdio_o(sdio)
  );
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // compare and count
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_host.xfer(1'b0, a, d, x);
  endtask : wr
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // hang guard, about three times the expected run
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
  // -----------------------------------------
  // main sequence
  // -----------------------------------------
  initial begin
    srst = 1'b1;
    repeat (5) @(posedge mclk);
    #1 srst = 1'b0;
    repeat (3) @(posedge mclk);
    // fuse defaults in force, unwritten select reads zero, power-down reads its reset 02
    chk(24'(map), 24'(F_MAP));
    chk(24'(mode), 24'(F_MODE));
    chk({21'h0, cbs, ras, cas}, 24'h0);
    u_host.xfer(1'b1, 12'h007, 8'h00, r);
    chk(24'(r), 24'h0);
    u_host.xfer(1'b1, 12'h008, 8'h00, r);
    chk(24'(r), 24'h02);
    u_host.xfer(1'b1, 12'h005, 8'h00, r);
    chk(24'(r), 24'h0);
    $display("test reset done");
    // ordinary writes, outputs and readback per row
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      chk({21'h0, cbs, ras, cas}, 24'(rows[k].slp));
      chk(obd, rows[k].obd);
      chk(24'(mode), 24'(rows[k].mode));
      chk(24'(map), 24'(F_MAP));
      u_host.xfer(1'b1, rows[k].a, 8'h00, r);
      chk(24'(r), 24'(rows[k].d));
    end
    $display("test table done");
    // mapper acts only at fuse load, which clears the other writes
    for (int m = 1; m < 7; m++) begin
      wr(12'h008, 8'h22);
      wr(12'h007, {m[2:0], 5'h0c});
      chk(24'(map), (m == 1) ? 24'(F_MAP) : 24'(m - 1));
      wr(12'h013, 8'h01);
      chk(24'(map), 24'(m));
      chk({21'h0, cbs, ras, cas}, 24'h0);
      chk(obd, 24'h0);
      u_host.xfer(1'b1, 12'h007, 8'h00, r);
      chk(24'(r), 24'({m[2:0], 5'h0c}));
    end
    $display("test fuse load done");
    // soft reset brings back fuse defaults and zero readback
    wr(12'h000, 8'h01);
    chk(24'(map), 24'(F_MAP));
    chk(24'(mode), 24'(F_MODE));
    u_host.xfer(1'b1, 12'h007, 8'h00, r);
    chk(24'(r), 24'h0);
    $display("test soft reset done");
    wrap_up();
  end
endmodule : conv_cfg_regs_tb_top
`default_nettype wire
